// ==== logic/system_clock_slew_control.sv ====
// System clock slew controller with APB register access
//
// How it works
// - three-bit step limit sets the largest divisor used while slewing
// - code 111 gives 128 down to 2 then the post divide ratio; 001 gives 2 only
// - code 000 means no intermediate divisor; jump straight to target
// - downward change walks divisors upward, from 2 to the limit
// - up-enable set slews on switch to higher frequency, else no slew
// - down-enable set slews on switch to lower frequency, else no slew
// - read-only busy bit is 1 while slewing, 0 once final value reached
// - four-bit writable field selects post divide ratio of system clock
// - both enables clear: post divide ignored, system clock divided by 1
// - bits 31 to 20 read zero and ignore writes
//
// Decided for this implementation: the register addresses and the APB slave port.
module system_clock_slew_control
  import slew_pkg::*;
#(
  parameter int DWELL_CYC = STEP_DWELL_CYC
) (
  input wire logic ref_clk, // Reference clock, 25 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [APB_AW-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic clkSwitchReq, // Frequency change request pulse
  input wire logic clkSwitchUp, // Change goes to higher frequency
  output logic system_clock_out, // System clock enable strobe
  output logic slewBusy, // Slewing in progress
  output logic irq // Interrupt level
);
  ////////////////////////////////////////////////////////////////////////////
  // Control register state
  logic [STEP_W-1:0] slew_step_limit_q, slew_step_limit_d;
  logic [POST_W-1:0] system_clock_out_post_divide_sel_q, system_clock_out_post_divide_sel_d;
  logic slew_up_enable_q, slew_up_enable_d;
  logic slew_down_enable_q, slew_down_enable_d;
  logic [EVT_N-1:0] irqMask_q, irqMask_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic pready_q;
  logic [EVT_N-1:0] statClr_d;
  logic [EVT_N-1:0] evtStat;
  logic [EVT_N-1:0] evt;
  logic setupPh, accessPh, wrCtrl, wrMask, rdStat, mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  slew_state_t state_q, state_d;
  logic [STEP_W-1:0] exp_q, exp_d;
  logic [STEP_W-1:0] limit_q, limit_d;
  logic dirUp_q, dirUp_d;
  logic [DWELL_W-1:0] dwell_q, dwell_d;
  logic busy_q, busy_d;
  logic slewOk;

  slew_div_if divBus ();

  always_comb
  begin
    setupPh = psel & ~penable;
    accessPh = psel & penable;
    mapped = (paddr == CTRL_OFS) || (paddr == IRQ_STAT_OFS) || (paddr == IRQ_MASK_OFS);
    wrCtrl = accessPh & pwrite & (paddr == CTRL_OFS);
    wrMask = accessPh & pwrite & (paddr == IRQ_MASK_OFS);
    rdStat = accessPh & ~pwrite & (paddr == IRQ_STAT_OFS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, honouring byte strobes
  always_comb
  begin
    slew_step_limit_d = slew_step_limit_q;
    system_clock_out_post_divide_sel_d = system_clock_out_post_divide_sel_q;
    slew_up_enable_d = slew_up_enable_q;
    slew_down_enable_d = slew_down_enable_q;
    irqMask_d = irqMask_q;
    if (wrCtrl && pstrb[0])
    begin
      slew_up_enable_d = pwdata[UP_EN_BIT];
      slew_down_enable_d = pwdata[DN_EN_BIT];
    end
    if (wrCtrl && pstrb[1])
    begin
      slew_step_limit_d = pwdata[STEP_LSB +: STEP_W];
    end
    if (wrCtrl && pstrb[2])
    begin
      system_clock_out_post_divide_sel_d = pwdata[POST_LSB +: POST_W];
    end
    // Byte 3 and the upper nibble of byte 2 hold nothing
    if (wrMask && pstrb[0])
    begin
      irqMask_d = pwdata[EVT_N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data captured in setup so it is a flop during access
  always_comb
  begin
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    statClr_d = '0;
    if (setupPh)
    begin
      prdata_d = '0;
      pslverr_d = ~mapped;
      if (paddr == CTRL_OFS)
      begin
        prdata_d[POST_LSB +: POST_W] = system_clock_out_post_divide_sel_q;
        prdata_d[STEP_LSB +: STEP_W] = slew_step_limit_q;
        prdata_d[UP_EN_BIT] = slew_up_enable_q;
        prdata_d[DN_EN_BIT] = slew_down_enable_q;
        prdata_d[BUSY_BIT] = busy_q;
      end
      else if (paddr == IRQ_STAT_OFS)
      begin
        prdata_d[EVT_N-1:0] = evtStat;
      end
      else if (paddr == IRQ_MASK_OFS)
      begin
        prdata_d[EVT_N-1:0] = irqMask_q;
      end
    end
    else if (accessPh)
    begin
      pslverr_d = pslverr_q;
    end
    // Clear only what the reader saw; later events survive the read
    if (rdStat)
    begin
      statClr_d = prdata_q[EVT_N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slew sequencer
  always_comb
  begin
    state_d = state_q;
    exp_d = exp_q;
    limit_d = limit_q;
    dirUp_d = dirUp_q;
    dwell_d = dwell_q;
    busy_d = busy_q;
    evt = '0;
    slewOk = clkSwitchUp ? slew_up_enable_q : slew_down_enable_q;
    case (state_q)
      ST_IDLE:
      begin
        // Requests during a slew are ignored; the limit is frozen per change
        if (clkSwitchReq && slewOk && (slew_step_limit_q != STEP_NONE))
        begin
          state_d = ST_STEP;
          limit_d = slew_step_limit_q;
          dirUp_d = clkSwitchUp;
          exp_d = clkSwitchUp ? slew_step_limit_q : STEP_DIV2;
          dwell_d = DWELL_W'(DWELL_CYC - 1);
          busy_d = 1'b1;
          evt[EVT_START] = 1'b1;
        end
      end
      ST_STEP:
      begin
        if (dwell_q != '0)
        begin
          dwell_d = dwell_q - 1'b1;
        end
        else if (dirUp_q ? (exp_q == STEP_DIV2) : (exp_q == limit_q))
        begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
          evt[EVT_DONE] = 1'b1;
        end
        else
        begin
          exp_d = dirUp_q ? exp_q - 1'b1 : exp_q + 1'b1;
          dwell_d = DWELL_W'(DWELL_CYC - 1);
        end
      end
      default:
      begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divide ratio: step divisor while slewing, else post divide, or 1 with both enables clear
  // A step shorter than its divisor ends before the divider reloads
  always_comb
  begin
    if (state_q == ST_STEP)
    begin
      divBus.ratioM1 = RATIO_W'((9'h001 << exp_q) - 9'h001);
    end
    else if (slew_up_enable_q || slew_down_enable_q)
    begin
      divBus.ratioM1 = RATIO_W'(system_clock_out_post_divide_sel_q);
    end
    else
    begin
      divBus.ratioM1 = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and mask register flops
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      slew_step_limit_q <= STEP_LIMIT_RST;
      system_clock_out_post_divide_sel_q <= POST_SEL_RST;
      slew_up_enable_q <= UP_EN_RST;
      slew_down_enable_q <= DN_EN_RST;
      irqMask_q <= '0;
    end
    else
    begin
      slew_step_limit_q <= slew_step_limit_d;
      system_clock_out_post_divide_sel_q <= system_clock_out_post_divide_sel_d;
      slew_up_enable_q <= slew_up_enable_d;
      slew_down_enable_q <= slew_down_enable_d;
      irqMask_q <= irqMask_d;
    end
  end

  // Zero wait states: every access ends in its first access cycle
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      pready_q <= 1'b1;
    end
  end

  // Sequencer flops
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      exp_q <= STEP_NONE;
      limit_q <= STEP_NONE;
      dirUp_q <= 1'b0;
      dwell_q <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      exp_q <= exp_d;
      limit_q <= limit_d;
      dirUp_q <= dirUp_d;
      dwell_q <= dwell_d;
      busy_q <= busy_d;
    end
  end

  // Clear is applied combinationally at the access edge
  slew_event_flags #(
    .N(EVT_N)
  ) u_flags (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .evt(evt),
    .clr(statClr_d),
    .mask(irqMask_q),
    .stat_q(evtStat),
    .irq_q(irq)
  );

  system_clock_out_strobe_divider u_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .div(divBus.div),
    .strobe_q(system_clock_out)
  );

  always_comb
  begin
    prdata = prdata_q;
    pready = pready_q;
    pslverr = pslverr_q;
    slewBusy = busy_q;
  end
endmodule

// ==== logic/slew_pkg.sv ====
// Shared constants and types for the system clock slew controller
package slew_pkg;
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
  localparam logic [APB_AW-1:0] IRQ_STAT_OFS = 12'h004;
  localparam logic [APB_AW-1:0] IRQ_MASK_OFS = 12'h008;

  localparam int BUSY_BIT = 0;
  localparam int DN_EN_BIT = 1;
  localparam int UP_EN_BIT = 2;
  localparam int STEP_LSB = 8;
  localparam int STEP_W = 3;
  localparam int POST_LSB = 16;
  localparam int POST_W = 4;

  localparam logic [STEP_W-1:0] STEP_LIMIT_RST = 3'h2;
  localparam logic [POST_W-1:0] POST_SEL_RST = 4'h0;
  localparam logic UP_EN_RST = 1'b1;
  localparam logic DN_EN_RST = 1'b0;
  localparam logic [STEP_W-1:0] STEP_NONE = 3'h0;
  localparam logic [STEP_W-1:0] STEP_DIV2 = 3'h1;

  localparam int EVT_N = 2;
  localparam int EVT_DONE = 0;
  localparam int EVT_START = 1;

  localparam int RATIO_W = 8;
  localparam int REF_CLK_HZ = 25000000;
  localparam int STEP_DWELL_NS = 1000;
  localparam int STEP_DWELL_CYC = (STEP_DWELL_NS * (REF_CLK_HZ / 1000000)) / 1000;
  localparam int DWELL_W = 16;

  typedef enum {ST_IDLE, ST_STEP} slew_state_t;
endpackage

// ==== logic/slew_div_if.sv ====
// Carrier for the divide ratio from the sequencer to the output divider
interface slew_div_if;
  import slew_pkg::*;
  logic [RATIO_W-1:0] ratioM1;
  modport ctl (output ratioM1);
  modport div (input ratioM1);
endinterface

// ==== logic/system_clock_out_strobe_divider.sv ====
// Divider that emits one enable strobe per divided clock period
module system_clock_out_strobe_divider
  import slew_pkg::*;
(
  input wire logic ref_clk, // Reference clock
  input wire logic resetn, // Async reset, active low
  slew_div_if.div div, // Ratio minus one
  output logic strobe_q // One strobe per period
);
  logic [RATIO_W-1:0] cnt_q, cnt_d;
  logic strobe_d;

  // Ratio change lands at the next period boundary, so no runt periods
  always_comb
  begin
    if (cnt_q == '0)
    begin
      cnt_d = div.ratioM1;
      strobe_d = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q - 1'b1;
      strobe_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= '0;
      strobe_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      strobe_q <= strobe_d;
    end
  end
endmodule

// ==== logic/slew_event_flags.sv ====
// Sticky event flags with mask and level interrupt
module slew_event_flags #(
  parameter int N = 2
) (
  input wire logic ref_clk, // Reference clock
  input wire logic resetn, // Async reset, active low
  input wire logic [N-1:0] evt, // Event pulses
  input wire logic [N-1:0] clr, // Bits to clear
  input wire logic [N-1:0] mask, // Interrupt enables
  output logic [N-1:0] stat_q, // Sticky flags
  output logic irq_q // Interrupt level
);
  logic [N-1:0] stat_d;
  logic irq_d;

  // Set beats clear in the same cycle
  for (genvar i = 0; i < N; i++)
  begin : g_flag
    always_comb
    begin
      stat_d[i] = evt[i] | (stat_q[i] & ~clr[i]);
    end
  end

  always_comb
  begin
    irq_d = |(stat_d & mask);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      irq_q <= irq_d;
    end
  end
endmodule

// ==== tb/slew_ctl_assertions.sv ====
// Port-level checks for the slew controller
module slew_ctl_assertions
  import slew_pkg::*;
#(
  parameter int DWELL_CYC = 2
) (
  input wire logic ref_clk, // Clock
  input wire logic resetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [APB_AW-1:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic pslverr, // Error
  input wire logic clkSwitchReq, // Request
  input wire logic system_clock_out, // Strobe
  input wire logic slewBusy // Busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] busyCnt_q;
  logic [15:0] busyCnt_d;
  logic hit;
  assign hit = paddr == CTRL_OFS || paddr == IRQ_STAT_OFS || paddr == IRQ_MASK_OFS;
  always_comb busyCnt_d = slewBusy ? busyCnt_q + 16'h1 : 16'h0;
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      busyCnt_q <= 16'h0;
    else
      busyCnt_q <= busyCnt_d;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_rd;
    psel && penable && !pwrite;
  endsequence
  sequence s_ctl_rd;
    s_rd ##0 paddr == CTRL_OFS;
  endsequence
  a_busy_cause: assert property ($rose(slewBusy) |-> $past(clkSwitchReq)) else $error("busy without request");
  a_step_hold: assert property ($rose(slewBusy) |-> slewBusy[*2]) else $error("step too short");
  a_busy_bound: assert property ($rose(slewBusy) |-> ##[1:1000] !slewBusy) else $error("slew never ends");
  a_dwell_whole: assert property ($fell(slewBusy) |-> busyCnt_q % DWELL_CYC == 0) else $error("partial step");
  a_step_count: assert property ($fell(slewBusy) |-> busyCnt_q <= 7 * DWELL_CYC) else $error("too many steps");
  a_top_zero: assert property (s_rd |-> prdata[31:20] == 12'h000) else $error("upper bits set");
  a_hole_zero: assert property (s_ctl_rd |-> prdata[15:11] == 5'h00 && prdata[7:3] == 5'h00)
    else $error("reserved bits set");
  a_busy_bit: assert property (s_ctl_rd |-> prdata[0] == $past(slewBusy)) else $error("busy bit wrong");
  a_unmapped_read: assert property (s_rd ##0 !hit |-> pslverr && prdata == 32'h0)
    else $error("unmapped read");
  a_slew_div: assert property (slewBusy[*4] ##0 system_clock_out |-> !$past(system_clock_out))
    else $error("undivided while slewing");
endmodule

bind system_clock_slew_control slew_ctl_assertions #(.DWELL_CYC(DWELL_CYC)) u_chk (.ref_clk(ref_clk),
  .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .clkSwitchReq(clkSwitchReq), .system_clock_out(system_clock_out), .slewBusy(slewBusy));

// ==== tb/system_clock_slew_control_tb_top.sv ====
// Self-checking bench for the slew controller
module system_clock_slew_control_tb_top
  import slew_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = 4;
  typedef struct {logic [31:0] ctrl; logic up; int busy; int per;} row_t;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, e, system_clock_out, slewBusy, irq;
  logic clkSwitchReq = 1'b0;
  logic clkSwitchUp = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  int b, p;
  row_t rows[8] = '{
    '{32'h0000_0104, 1'b1, DW, 1},
    '{32'h0002_0304, 1'b1, 3 * DW, 3},
    '{32'h0000_0702, 1'b0, 7 * DW, 1},
    '{32'h0000_0004, 1'b1, 0, 1},
    '{32'h0000_0202, 1'b1, 0, 1},
    '{32'h0000_0204, 1'b0, 0, 1},
    '{32'h0005_0200, 1'b1, 0, 1},
    '{32'hffff_ffff, 1'b0, 7 * DW, 16}
  };
  system_clock_slew_control #(.DWELL_CYC(DW)) dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clkSwitchReq(clkSwitchReq), .clkSwitchUp(clkSwitchUp),
    .system_clock_out(system_clock_out), .slewBusy(slewBusy), .irq(irq));
  ////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [APB_AW-1:0] a, logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic req(logic up);
    @(posedge ref_clk);
    clkSwitchReq <= 1'b1;
    clkSwitchUp <= up;
    @(posedge ref_clk);
    clkSwitchReq <= 1'b0;
  endtask
  // Period taken after two strobes so a pending ratio change has landed
  task automatic slew(logic up, output int busy, output int per);
    req(up);
    busy = 0;
    per = 0;
    repeat (8 * DW + 20)
    begin
      @(posedge ref_clk);
      if (slewBusy === 1'b1)
        busy++;
    end
    for (int k = 0; k < 2; k++)
      do @(posedge ref_clk); while (system_clock_out !== 1'b1);
    do
    begin
      @(posedge ref_clk);
      per++;
    end
    while (system_clock_out !== 1'b1 && per < 40);
  endtask
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    #(40 * 20000);
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen timeout");
    wrap_up();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    apb(1'b0, CTRL_OFS, '0, r, e);
    chk("ctrl reset", 32'h0000_0204, r);
    apb(1'b0, 12'h00c, '0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    foreach (rows[i])
    begin
      apb(1'b1, CTRL_OFS, rows[i].ctrl, r, e);
      apb(1'b0, CTRL_OFS, '0, r, e);
      chk("ctrl readback", rows[i].ctrl & 32'h000f_0706, r);
      slew(rows[i].up, b, p);
      chk("busy cycles", rows[i].busy, b);
      chk("final period", rows[i].per, p);
      apb(1'b0, IRQ_STAT_OFS, '0, r, e);
      chk("events", rows[i].busy > 0 ? 32'h3 : 32'h0, r);
    end
    // Busy bit seen mid-slew, then done event drives the interrupt
    apb(1'b1, IRQ_MASK_OFS, 32'h1, r, e);
    apb(1'b1, CTRL_OFS, 32'h0000_0304, r, e);
    req(1'b1);
    apb(1'b0, CTRL_OFS, '0, r, e);
    chk("busy bit", 32'h1, {31'h0, r[0]});
    chk("irq early", 32'h0, {31'h0, irq});
    repeat (4 * DW + 10) @(posedge ref_clk);
    chk("irq set", 32'h1, {31'h0, irq});
    apb(1'b0, IRQ_STAT_OFS, '0, r, e);
    chk("status", 32'h3, r);
    repeat (2) @(posedge ref_clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    // Partial strobes: only the step-limit byte lands
    apb(1'b1, CTRL_OFS, 32'h0000_0004, r, e);
    pstrb <= 4'h2;
    apb(1'b1, CTRL_OFS, 32'h000f_0103, r, e);
    pstrb <= 4'hf;
    apb(1'b0, CTRL_OFS, '0, r, e);
    chk("strobed write", 32'h0000_0104, r);
    // Done event on the clearing edge of a status read survives it
    req(1'b1);
    repeat (2 * DW) @(posedge ref_clk);
    req(1'b1);
    repeat (DW - 3) @(posedge ref_clk);
    apb(1'b0, IRQ_STAT_OFS, '0, r, e);
    chk("status at done", 32'h3, r);
    apb(1'b0, IRQ_STAT_OFS, '0, r, e);
    chk("done kept", 32'h1, r);
    // Reset in mid-run returns the control and status registers to their reset values
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("irq in reset", 32'h0, {31'h0, irq});
    resetn <= 1'b1;
    apb(1'b0, CTRL_OFS, '0, r, e);
    chk("ctrl after reset", 32'h0000_0204, r);
    apb(1'b0, IRQ_STAT_OFS, '0, r, e);
    chk("status after reset", 32'h0, r);
    wrap_up();
  end
endmodule
